// [verilog/crb_top.sv]
// cpu general-purpose register bank and data-area address decoder
// Notes on behaviour
// - one megabyte space, 20-bit addresses, holding rom, data area and external memory
// - data area placement follows the relocation instruction operand
// - operand zero: data area 0FB00H-0FFFFH, rom 00000H-07FFFH
// - operand 0FH: data area moves to top of space, rom unchanged
// - other addresses go external only in expansion mode
// - reset never alters internal ram or banked registers
// - sixteen byte registers per bank
// - adjacent byte pairs act as one 16-bit register
// - four pairs join an expansion byte to make 24-bit pointers
// - eight register sets, chosen by software or context switch
// - banked registers live in ram, expansion bytes outside it
// - alias bit set: bytes 4-7 and pairs 2,3 answer legacy encodings
// - special registers sit in the top 256 bytes of the data area
`timescale 1ns/1ns
`include "crb_cfg.svh"
module crb_top (
  input  wire logic                  core_clk_i,
  input  wire logic                  arst_n_i,
  input  wire crb_pkg::crb_reg_req_t reg_req_i,
  input  wire logic [1:0]            ptr_sel_i,
  input  wire logic                  legacy_alias_select_i,
  input  wire logic                  bank_we_i,
  input  wire logic [2:0]            bank_wdata_i,
  input  wire logic                  ctx_switch_i,
  input  wire logic [2:0]            ctx_bank_i,
  input  wire logic                  reloc_exec_i,
  input  wire logic [3:0]            reloc_op_i,
  input  wire logic                  ext_mode_i,
  input  wire crb_pkg::crb_mem_req_t mem_req_i,
  output logic                       reg_ack_o,
  output logic                       reg_err_o,
  output logic [23:0]                reg_rdata_o,
  output logic                       mem_ack_o,
  output logic [7:0]                 mem_rdata_o,
  output crb_pkg::crb_dec_t          dec_o,
  output logic [2:0]                 bank_o,
  output logic                       reloc_done_o,
  output logic                       reloc_high_o
);
  // ---------------- relocation state
  crb_pkg::crb_loc_state_t loc_state;
  crb_pkg::crb_loc_state_t next_loc_state;
  always_comb begin
    next_loc_state = loc_state;
    case (loc_state)
      crb_pkg::CRB_LOC_DEFAULT: begin
        // an operand other than the two legal ones leaves the default in place
        if (reloc_exec_i && reloc_op_i == `CRB_OP_LOW) next_loc_state = crb_pkg::CRB_LOC_LOW;
        if (reloc_exec_i && reloc_op_i == `CRB_OP_HIGH) next_loc_state = crb_pkg::CRB_LOC_HIGH;
      end
      // later relocations are ignored; the placement is frozen until reset
      crb_pkg::CRB_LOC_LOW:  next_loc_state = crb_pkg::CRB_LOC_LOW;
      crb_pkg::CRB_LOC_HIGH: next_loc_state = crb_pkg::CRB_LOC_HIGH;
      default:               next_loc_state = crb_pkg::CRB_LOC_DEFAULT;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loc_state <= crb_pkg::CRB_LOC_DEFAULT;
    end else begin
      loc_state <= next_loc_state;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reloc_done_o <= 1'b0;
      reloc_high_o <= 1'b0;
    end else begin
      reloc_done_o <= (next_loc_state != crb_pkg::CRB_LOC_DEFAULT);
      reloc_high_o <= (next_loc_state == crb_pkg::CRB_LOC_HIGH);
    end
  end

  // ---------------- bank select
  logic [`CRB_BANK_W-1:0] next_bank;
  always_comb begin
    next_bank = bank_o;
    if (bank_we_i) next_bank = bank_wdata_i;
    // the context switch wins when both arrive together
    if (ctx_switch_i) next_bank = ctx_bank_i;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_o <= `CRB_BANK_RESET;
    end else begin
      bank_o <= next_bank;
    end
  end

  // ---------------- address decode of the memory port
  logic                      is_high;
  logic [3:0]                page;
  logic                      in_data;
  logic                      in_sfr;
  logic                      in_rom;
  logic [15:0]               data_ofs;
  crb_pkg::crb_dec_t         dec_now;
  always_comb begin
    is_high  = (loc_state == crb_pkg::CRB_LOC_HIGH);
    page     = is_high ? `CRB_PAGE_HIGH : `CRB_PAGE_LOW;
    in_data  = (mem_req_i.addr[19:16] == page) && (mem_req_i.addr[15:0] >= `CRB_DATA_LO);
    in_sfr   = in_data && (mem_req_i.addr[15:0] >= `CRB_SFR_LO);
    in_rom   = (mem_req_i.addr <= `CRB_ROM_LAST);
    data_ofs = mem_req_i.addr[15:0] - `CRB_DATA_LO;
    dec_now.rom   = in_rom;
    dec_now.ram   = in_data && !in_sfr;
    dec_now.sfr   = in_sfr;
    // everything else of the 20-bit space is external, if expansion is on
    dec_now.ext   = !in_rom && !in_data && ext_mode_i;
    dec_now.fault = !in_rom && !in_data && !ext_mode_i;
  end

  // ---------------- register address formation
  logic                       reg_bad;
  logic                       eff_pair;
  logic [3:0]                 eff_idx;
  logic [`CRB_RAM_OFS_W-1:0]  reg_ofs;
  logic                       reg_go;
  logic                       reg_wr_ram;
  logic                       ptr_wr;
  always_comb begin
    reg_bad  = 1'b0;
    eff_pair = reg_req_i.pair;
    eff_idx  = reg_req_i.idx;
    if (reg_req_i.ptr) begin
      eff_pair = 1'b1;
      eff_idx  = {1'b0, `CRB_PTR_PAIR_BASE + {1'b0, ptr_sel_i}};
    end else if (reg_req_i.legacy) begin
      reg_bad = !legacy_alias_select_i;
      if (reg_req_i.idx[2:0] < `CRB_LEG_AX) begin
        eff_pair = 1'b0;
        eff_idx  = `CRB_LEG_BYTE_BASE + {2'h0, reg_req_i.idx[1:0]};
      end else if (reg_req_i.idx[2:0] == `CRB_LEG_AX) begin
        eff_pair = 1'b1;
        eff_idx  = {1'b0, `CRB_PAIR_TWO};
      end else if (reg_req_i.idx[2:0] == `CRB_LEG_BC) begin
        eff_pair = 1'b1;
        eff_idx  = {1'b0, `CRB_PAIR_THREE};
      end else begin
        reg_bad = 1'b1;
      end
    end
    // a pair index p addresses bytes 2p and 2p+1, the low byte even
    reg_ofs    = `CRB_REG_BASE + {3'h0, bank_o, 4'h0}
               + (eff_pair ? {5'h00, eff_idx[2:0], 1'b0} : {6'h00, eff_idx});
    reg_go     = reg_req_i.valid && !reg_bad;
    reg_wr_ram = reg_go && reg_req_i.we;
    ptr_wr     = reg_wr_ram && reg_req_i.ptr;
  end

  // ---------------- ram ports
  logic [1:0]  a_be;
  logic [15:0] a_wdata;
  logic [15:0] a_rdata;
  logic        b_en;
  logic [1:0]  b_be;
  logic [15:0] b_rdata;
  always_comb begin
    a_wdata = eff_pair ? reg_req_i.wdata[15:0] : {2{reg_req_i.wdata[7:0]}};
    a_be    = 2'h0;
    if (reg_wr_ram) a_be = eff_pair ? 2'h3 : (reg_ofs[0] ? 2'h2 : 2'h1);
    b_en    = mem_req_i.valid && dec_now.ram;
    b_be    = 2'h0;
    if (b_en && mem_req_i.we) b_be = data_ofs[0] ? 2'h2 : 2'h1;
  end
  crb_ram u_ram (
    .clk_i     (core_clk_i),
    .a_en_i    (reg_go),
    .a_be_i    (a_be),
    .a_addr_i  (reg_ofs[`CRB_RAM_OFS_W-1:1]),
    .a_wdata_i (a_wdata),
    .a_rdata_o (a_rdata),
    .b_en_i    (b_en),
    .b_be_i    (b_be),
    .b_addr_i  (data_ofs[`CRB_RAM_OFS_W-1:1]),
    .b_wdata_i ({2{mem_req_i.wdata}}),
    .b_rdata_o (b_rdata)
  );

  // ---------------- expansion bytes, kept in flops outside the ram
  logic [7:0] exp_q    [`CRB_PTR_COUNT];
  logic [7:0] next_exp [`CRB_PTR_COUNT];
  for (genvar gi = 0; gi < `CRB_PTR_COUNT; gi++) begin : g_exp
    always_comb begin
      next_exp[gi] = exp_q[gi];
      if (ptr_wr && ptr_sel_i == 2'(gi)) next_exp[gi] = reg_req_i.wdata[23:16];
    end

    // these are not ram, so unlike the banked bytes they do reset
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        exp_q[gi] <= `CRB_EXP_RESET;
      end else begin
        exp_q[gi] <= next_exp[gi];
      end
    end
  end

  // ---------------- stage one: wait for ram read data
  logic              s1_reg;
  logic              s1_err;
  logic              s1_pair;
  logic              s1_ptr;
  logic              s1_lane;
  logic [7:0]        s1_exp;
  logic              s1_mem;
  logic              s1_mlane;
  crb_pkg::crb_dec_t s1_dec;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg   <= 1'b0;
      s1_err   <= 1'b0;
      s1_pair  <= 1'b0;
      s1_ptr   <= 1'b0;
      s1_lane  <= 1'b0;
      s1_exp   <= 8'h00;
      s1_mem   <= 1'b0;
      s1_mlane <= 1'b0;
      s1_dec   <= '0;
    end else begin
      s1_reg   <= reg_req_i.valid;
      s1_err   <= reg_req_i.valid && reg_bad;
      s1_pair  <= eff_pair;
      s1_ptr   <= reg_req_i.ptr;
      s1_lane  <= reg_ofs[0];
      s1_exp   <= exp_q[ptr_sel_i];
      s1_mem   <= mem_req_i.valid;
      s1_mlane <= data_ofs[0];
      s1_dec   <= dec_now;
    end
  end

  // ---------------- stage two: registered answers
  logic [23:0]       next_reg_rdata;
  logic [7:0]        next_mem_rdata;
  always_comb begin
    next_reg_rdata = 24'h000000;
    if (s1_reg && !s1_err) begin
      if (s1_pair) next_reg_rdata = {s1_ptr ? s1_exp : 8'h00, a_rdata};
      else         next_reg_rdata = {16'h0000, s1_lane ? a_rdata[15:8] : a_rdata[7:0]};
    end
    // only ram bytes come back; rom, sfr and external data are served elsewhere
    next_mem_rdata = 8'h00;
    if (s1_mem && s1_dec.ram) next_mem_rdata = s1_mlane ? b_rdata[15:8] : b_rdata[7:0];
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_ack_o   <= 1'b0;
      reg_err_o   <= 1'b0;
      reg_rdata_o <= 24'h000000;
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 8'h00;
      dec_o       <= '0;
    end else begin
      reg_ack_o   <= s1_reg;
      reg_err_o   <= s1_err;
      reg_rdata_o <= next_reg_rdata;
      mem_ack_o   <= s1_mem;
      mem_rdata_o <= next_mem_rdata;
      dec_o       <= s1_mem ? s1_dec : '0;
    end
  end

  // ---------------- assertions
  property p_rom_map;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      mem_req_i.valid && mem_req_i.addr <= `CRB_ROM_LAST |-> ##2 mem_ack_o && dec_o.rom && !dec_o.ram;
  endproperty
  a_rom_map: assert property (p_rom_map) else $error("rom address not decoded as rom");
  property p_data_low;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      mem_req_i.valid && loc_state != crb_pkg::CRB_LOC_HIGH && mem_req_i.addr[19:16] == `CRB_PAGE_LOW
      && mem_req_i.addr[15:0] >= `CRB_DATA_LO |-> ##2 (dec_o.ram || dec_o.sfr) && !dec_o.ext;
  endproperty
  a_data_low: assert property (p_data_low) else $error("low data area missed");
  property p_data_high;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      mem_req_i.valid && reloc_high_o && mem_req_i.addr[19:16] == `CRB_PAGE_HIGH
      && mem_req_i.addr[15:0] >= `CRB_DATA_LO |-> ##2 (dec_o.ram || dec_o.sfr);
  endproperty
  a_data_high: assert property (p_data_high) else $error("high data area missed");
  property p_sfr_win;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      mem_ack_o && dec_o.sfr |-> $past(mem_req_i.addr[15:0], 2) >= `CRB_SFR_LO;
  endproperty
  a_sfr_win: assert property (p_sfr_win) else $error("sfr flag outside window");
  property p_ext_mode;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      mem_ack_o && (dec_o.ext || dec_o.fault) |-> $past(ext_mode_i, 2) == dec_o.ext && !dec_o.rom;
  endproperty
  a_ext_mode: assert property (p_ext_mode) else $error("external routing ignores expansion mode");
  property p_reloc_frozen;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      reloc_done_o && reloc_exec_i |=> $stable(reloc_high_o) ##1 $stable(reloc_high_o);
  endproperty
  a_reloc_frozen: assert property (p_reloc_frozen) else $error("placement changed after first relocation");
  property p_reloc_take;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      !reloc_done_o && reloc_exec_i && reloc_op_i == `CRB_OP_HIGH |=> reloc_done_o && reloc_high_o;
  endproperty
  a_reloc_take: assert property (p_reloc_take) else $error("high relocation not taken");
  property p_default_low;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      !reloc_done_o && mem_req_i.valid && mem_req_i.addr[19:16] == `CRB_PAGE_HIGH
      && mem_req_i.addr[15:0] >= `CRB_DATA_LO |-> ##2 !dec_o.ram && !dec_o.sfr;
  endproperty
  a_default_low: assert property (p_default_low) else $error("high placement before relocation");
  property p_ctx_bank;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      ctx_switch_i |=> bank_o == $past(ctx_bank_i);
  endproperty
  a_ctx_bank: assert property (p_ctx_bank) else $error("context switch bank not applied");
  property p_alias_off;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      reg_req_i.valid && reg_req_i.legacy && !reg_req_i.ptr && !legacy_alias_select_i
      |-> ##2 reg_ack_o && reg_err_o && reg_rdata_o == 24'h000000;
  endproperty
  a_alias_off: assert property (p_alias_off) else $error("legacy encoding served with alias off");
  property p_ptr_exp;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      reg_req_i.valid && reg_req_i.ptr && !reg_req_i.we
      |-> ##2 reg_rdata_o[23:16] == $past(exp_q[ptr_sel_i], 2);
  endproperty
  a_ptr_exp: assert property (p_ptr_exp) else $error("pointer top byte wrong");
endmodule // crb_top

// [verilog/crb_cfg.svh]
// address map, register layout and encoding constants for the cpu register bank
`ifndef CRB_CFG_SVH
`define CRB_CFG_SVH

`define CRB_ADDR_W        20
`define CRB_ROM_LAST      20'h07FFF
`define CRB_DATA_LO       16'hFB00
`define CRB_SFR_LO        16'hFF00
`define CRB_PAGE_LOW      4'h0
`define CRB_PAGE_HIGH     4'hF
`define CRB_OP_LOW        4'h0
`define CRB_OP_HIGH       4'hF
`define CRB_RAM_OFS_W     10
`define CRB_RAM_AW        9
`define CRB_RAM_DEPTH     512
`define CRB_REG_BASE      10'h380
`define CRB_BANK_W        3
`define CRB_BANK_RESET    3'h0
`define CRB_LEG_AX        3'h4
`define CRB_LEG_BC        3'h5
`define CRB_LEG_BYTE_BASE 4'h4
`define CRB_PAIR_TWO      3'h2
`define CRB_PAIR_THREE    3'h3
`define CRB_PTR_PAIR_BASE 3'h4
`define CRB_PTR_COUNT     4
`define CRB_EXP_RESET     8'h00

`endif

// [verilog/crb_pkg.sv]
// types shared by the cpu register bank and address map
package crb_pkg;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic        pair;
    logic        ptr;
    logic        legacy;
    logic [3:0]  idx;
    logic [23:0] wdata;
  } crb_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } crb_mem_req_t;

  typedef struct packed {
    logic rom;
    logic ram;
    logic sfr;
    logic ext;
    logic fault;
  } crb_dec_t;

  typedef enum logic [1:0] {
    CRB_LOC_DEFAULT = 2'h0,
    CRB_LOC_LOW     = 2'h1,
    CRB_LOC_HIGH    = 2'h2
  } crb_loc_state_t;

endpackage

// [verilog/crb_ram.sv]
// internal ram: two 16-bit ports with byte enables, registered read, no reset
`timescale 1ns/1ns
`include "crb_cfg.svh"
module crb_ram (
  input  wire logic                   clk_i,
  input  wire logic                   a_en_i,
  input  wire logic [1:0]             a_be_i,
  input  wire logic [`CRB_RAM_AW-1:0] a_addr_i,
  input  wire logic [15:0]            a_wdata_i,
  output logic      [15:0]            a_rdata_o,
  input  wire logic                   b_en_i,
  input  wire logic [1:0]             b_be_i,
  input  wire logic [`CRB_RAM_AW-1:0] b_addr_i,
  input  wire logic [15:0]            b_wdata_i,
  output logic      [15:0]            b_rdata_o
);
  logic [15:0] mem [`CRB_RAM_DEPTH];

  // contents survive chip reset, so the array has no reset at all
  always_ff @(posedge clk_i) begin
    if (b_en_i) begin
      b_rdata_o <= mem[b_addr_i];
      if (b_be_i[0]) mem[b_addr_i][7:0]  <= b_wdata_i[7:0];
      if (b_be_i[1]) mem[b_addr_i][15:8] <= b_wdata_i[15:8];
    end
    // port a is written last, so it wins a same-word collision
    if (a_en_i) begin
      a_rdata_o <= mem[a_addr_i];
      if (a_be_i[0]) mem[a_addr_i][7:0]  <= a_wdata_i[7:0];
      if (a_be_i[1]) mem[a_addr_i][15:8] <= a_wdata_i[15:8];
    end
  end
endmodule // crb_ram

// [testbench/crb_top_tb.sv]
// self-checking bench for the cpu register bank and address decoder
`timescale 1ns/1ns
module crb_top_tb;
  logic                  core_clk_i = 1'b0;
  logic                  arst_n_i = 1'b0;
  crb_pkg::crb_reg_req_t reg_req_i = '0;
  logic [1:0]            ptr_sel_i = 2'h0;
  logic                  legacy_alias_select_i = 1'b0;
  logic                  bank_we_i = 1'b0;
  logic [2:0]            bank_wdata_i = 3'h0;
  logic                  ctx_switch_i = 1'b0;
  logic [2:0]            ctx_bank_i = 3'h0;
  logic                  reloc_exec_i = 1'b0;
  logic [3:0]            reloc_op_i = 4'h0;
  logic                  ext_mode_i = 1'b0;
  crb_pkg::crb_mem_req_t mem_req_i = '0;
  logic                  reg_ack_o;
  logic                  reg_err_o;
  logic [23:0]           reg_rdata_o;
  logic                  mem_ack_o;
  logic [7:0]            mem_rdata_o;
  crb_pkg::crb_dec_t     dec_o;
  logic [2:0]            bank_o;
  logic                  reloc_done_o;
  logic                  reloc_high_o;
  int                    n_fail = 0;
  int                    total_checks = 0;
  int                    cyc = 0;
  // mirror of the whole internal ram; banked registers live at 380H + 16*bank + index
  logic [7:0]            ram_m [0:1023];
  logic [7:0]            exp_m [0:3];
  logic [2:0]            bk;
  logic                  hi;
  logic                  done;
  int                    rq_at [$];
  logic [24:0]           rq_v [$];
  int                    mq_at [$];
  logic [13:0]           mq_v [$];
  logic [19:0]           tbl [12] = '{20'h00000, 20'h07FFF, 20'h08000, 20'h0FAFF, 20'h0FB00, 20'h0FEFF,
                                      20'h0FF00, 20'h0FFFF, 20'hFFB00, 20'hFFEFF, 20'hFFFFF, 20'h5FB00};

  crb_top uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i), .ptr_sel_i(ptr_sel_i),
    .legacy_alias_select_i(legacy_alias_select_i), .bank_we_i(bank_we_i), .bank_wdata_i(bank_wdata_i),
    .ctx_switch_i(ctx_switch_i), .ctx_bank_i(ctx_bank_i), .reloc_exec_i(reloc_exec_i), .reloc_op_i(reloc_op_i),
    .ext_mode_i(ext_mode_i), .mem_req_i(mem_req_i), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
    .reg_rdata_o(reg_rdata_o), .mem_ack_o(mem_ack_o), .mem_rdata_o(mem_rdata_o), .dec_o(dec_o),
    .bank_o(bank_o), .reloc_done_o(reloc_done_o), .reloc_high_o(reloc_high_o));

  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;

  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic nxt;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic quiet;
    reg_req_i.valid = 1'b0;
    mem_req_i.valid = 1'b0;
  endtask

  task automatic rreq(logic we, logic pr, logic pt, logic lg, logic [3:0] ix, logic [23:0] d,
                      logic [1:0] sl = 2'h0);
    int          b;
    logic        er;
    logic [23:0] old;
    reg_req_i = {1'b1, we, pr, pt, lg, ix, d};
    ptr_sel_i = sl;
    mem_req_i.valid = 1'b0;
    er = lg && (!legacy_alias_select_i || ix[2:0] > 3'h5);
    if (lg && ix[2:0] < 3'h4)
      ix = ix + 4'h4;
    else if (lg) begin
      pr = 1'b1;
      ix = ix - 4'h2;
    end
    b = 'h380 + 16 * bk + (pt ? 8 + 2 * sl : pr ? 2 * ix[2:0] : ix);
    old = pt ? {exp_m[sl], ram_m[b+1], ram_m[b]} : pr ? {8'h00, ram_m[b+1], ram_m[b]} : {16'h0000, ram_m[b]};
    if (er)
      old = '0;
    rq_at.push_back(cyc + 2);
    rq_v.push_back({er, old});
    if (we && !er) begin
      ram_m[b] = d[7:0];
      if (pt || pr)
        ram_m[b+1] = d[15:8];
      if (pt)
        exp_m[sl] = d[23:16];
    end
    nxt;
  endtask

  task automatic mreq(logic we, logic [19:0] ad, logic [7:0] d = 8'h00);
    crb_pkg::crb_dec_t e;
    logic [9:0]        o;
    mem_req_i = {1'b1, we, ad, d};
    reg_req_i.valid = 1'b0;
    o = 10'(ad[15:0] - 16'hFB00);
    e = '0;
    if (ad <= 20'h07FFF)
      e.rom = 1'b1;
    else if (ad[19:16] == {4{hi}} && ad[15:0] >= 16'hFB00) begin
      e.sfr = ad[15:0] >= 16'hFF00;
      e.ram = !e.sfr;
    end else if (ext_mode_i)
      e.ext = 1'b1;
    else
      e.fault = 1'b1;
    mq_at.push_back(cyc + 2);
    mq_v.push_back({!we, e, e.ram ? ram_m[o] : 8'h00});
    if (we && e.ram)
      ram_m[o] = d;
    nxt;
  endtask

  task automatic setbank(logic sw, logic [2:0] s, logic cx, logic [2:0] c);
    quiet;
    bank_we_i = sw;
    bank_wdata_i = s;
    ctx_switch_i = cx;
    ctx_bank_i = c;
    bk = cx ? c : s;
    nxt;
    bank_we_i = 1'b0;
    ctx_switch_i = 1'b0;
    nxt;
    check("bank_o", bank_o, bk);
  endtask

  task automatic reloc(logic [3:0] op);
    quiet;
    reloc_exec_i = 1'b1;
    reloc_op_i = op;
    if (!done && (op == 4'h0 || op == 4'hF)) begin
      done = 1'b1;
      hi = op[0];
    end
    nxt;
    reloc_exec_i = 1'b0;
    nxt;
    check("reloc state", {reloc_done_o, reloc_high_o}, {done, hi});
  endtask

  task automatic do_reset;
    quiet;
    if (arst_n_i) repeat (3) nxt; // let answers in flight drain before a mid-run reset
    arst_n_i = 1'b0;
    bk = 3'h0;
    hi = 1'b0;
    done = 1'b0;
    foreach (exp_m[i]) exp_m[i] = 8'h00;
    repeat (5) nxt;
    check("outputs in reset", {reg_ack_o, mem_ack_o, dec_o, bank_o, reloc_done_o, reloc_high_o}, 0);
    arst_n_i = 1'b1;
    nxt;
  endtask

  // each sweep runs the same addresses with expansion mode off and on
  task automatic sweep;
    foreach (tbl[k]) for (int x = 0; x < 2; x++) begin
      ext_mode_i = x[0];
      mreq(1'b0, tbl[k]);
    end
  endtask

  always @(negedge core_clk_i) begin : mon
    logic [24:0] rv;
    logic [13:0] mv;
    if (arst_n_i === 1'b1 && reg_ack_o !== 1'b0) begin
      if (rq_at.size() == 0)
        check("spare reg ack", 1, 0);
      else begin
        rv = rq_v.pop_front();
        check("reg ack cycle", cyc, rq_at.pop_front());
        check("reg_err_o", reg_err_o, rv[24]);
        check("reg_rdata_o", reg_rdata_o, rv[23:0]);
      end
    end
    if (arst_n_i === 1'b1 && mem_ack_o !== 1'b0) begin
      if (mq_at.size() == 0)
        check("spare mem ack", 1, 0);
      else begin
        mv = mq_v.pop_front();
        check("mem ack cycle", cyc, mq_at.pop_front());
        check("dec_o", dec_o, mv[12:8]);
        if (mv[13])
          check("mem_rdata_o", mem_rdata_o, mv[7:0]);
      end
    end else if (arst_n_i === 1'b1)
      check("idle dec_o", dec_o, 0);
  end

  initial begin
    #(8 * 5000);
    n_fail++;
    stop_test;
  end

  initial begin
    void'($urandom(88));
    do_reset;
    for (int b = 0; b < 8; b++) begin
      setbank(1'b1, 3'(b), 1'b0, 3'h0);
      for (int i = 0; i < 16; i++) rreq(1'b1, 1'b0, 1'b0, 1'b0, 4'(i), 24'($urandom));
    end
    for (int b = 0; b < 8; b++) begin
      setbank(1'b1, 3'(b), 1'b0, 3'h0);
      for (int i = 0; i < 16; i++) rreq(1'b0, 1'b0, 1'b0, 1'b0, 4'(i), 24'h0);
    end
    for (int p = 0; p < 8; p++) begin
      rreq(1'b1, 1'b1, 1'b0, 1'b0, 4'(p), 24'($urandom));
      rreq(1'b0, 1'b1, 1'b0, 1'b0, 4'(p), 24'h0);
      rreq(1'b0, 1'b0, 1'b0, 1'b0, 4'(2 * p + 1), 24'h0);
    end
    for (int s = 0; s < 4; s++) begin
      rreq(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 24'($urandom), 2'(s));
      rreq(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 24'h0, 2'(s));
      rreq(1'b0, 1'b1, 1'b0, 1'b0, 4'(4 + s), 24'h0);
    end
    // legacy encoding while the alias bit is clear must be refused and leave byte 4 alone
    rreq(1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 24'h0000AA);
    legacy_alias_select_i = 1'b1;
    for (int c = 0; c < 8; c++) begin
      rreq(1'b1, 1'b0, 1'b0, 1'b1, 4'(c), 24'($urandom));
      rreq(1'b0, 1'b0, 1'b0, 1'b1, 4'(c), 24'h0);
      rreq(1'b0, 1'b1, 1'b0, 1'b0, 4'(c % 4), 24'h0);
    end
    legacy_alias_select_i = 1'b0;
    setbank(1'b0, 3'h0, 1'b1, 3'h5);
    mreq(1'b1, 20'h0FB00, 8'($urandom));
    mreq(1'b1, 20'(20'h0FE80 + 16 * 5 + 3), 8'h5A);
    rreq(1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 24'h0);
    for (int k = 0; k < 8; k++) mreq(1'b0, 20'(20'h0FE80 + $urandom_range(127)));
    setbank(1'b1, 3'h2, 1'b1, 3'h6);
    rreq(1'b0, 1'b0, 1'b0, 1'b0, 4'h9, 24'h0);
    sweep;
    // reset in mid-run: ram and banked registers survive, expansion bytes clear
    do_reset;
    rreq(1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 24'h0);
    rreq(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 24'h0, 2'h1);
    reloc(4'h3);
    mreq(1'b0, 20'hFFB10);
    reloc(4'hF);
    reloc(4'h0);
    sweep;
    quiet;
    repeat (4) nxt;
    check("reg answers left", rq_at.size(), 0);
    check("mem answers left", mq_at.size(), 0);
    stop_test;
  end
endmodule // crb_top_tb
